// ===== addr_gen_pkg.sv
package addr_gen_pkg;

  // segment selector codes
  typedef enum logic [2:0] {
    SEG_STRING_TARGET = 3'h0,
    SEG_CODE          = 3'h1,
    SEG_STACK         = 3'h2,
    SEG_DATA          = 3'h3,
    SEG_AUX_ONE       = 3'h4,
    SEG_AUX_TWO       = 3'h5
  } seg_t;

  // kind of memory reference supplied by the decoder
  typedef enum logic [2:0] {
    REF_CODE_FETCH  = 3'h0,
    REF_STACK_PUSH  = 3'h1,
    REF_STACK_POP   = 3'h2,
    REF_STRING_DEST = 3'h3,
    REF_DATA        = 3'h4
  } ref_t;

  // operand / addressing modes
  typedef enum logic [2:0] {
    MODE_REGISTER       = 3'h0,
    MODE_IMMEDIATE      = 3'h1,
    MODE_DIRECT         = 3'h2,
    MODE_REG_INDIRECT   = 3'h3,
    MODE_BASED          = 3'h4,
    MODE_SCALED_INDEX   = 3'h5,
    MODE_BASED_SCALED   = 3'h6,
    MODE_BASED_SCALED_D = 3'h7
  } mode_t;

  // displacement field width
  typedef enum logic [1:0] {
    DISP_NONE = 2'h0,
    DISP_8    = 2'h1,
    DISP_16   = 2'h2,
    DISP_32   = 2'h3
  } disp_t;

  // operand width
  typedef enum logic [1:0] {
    SIZE_8  = 2'h0,
    SIZE_16 = 2'h1,
    SIZE_32 = 2'h2
  } size_t_t;

  // pipeline state
  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_EXTRA = 2'h1,
    ST_DONE  = 2'h2
  } state_t;

  localparam int        PHYS_WIDTH   = 24;
  localparam int        LIN_WIDTH    = 32;
  localparam logic [3:0] REG_FRAME   = 4'h5; // frame base pointer index
  localparam logic [3:0] REG_STACK   = 4'h4; // stack top pointer index
  localparam logic [3:0] REG_BASE16  = 4'h3; // 16-bit base register index
  localparam logic [3:0] REG_SRC16   = 4'h6; // 16-bit source index
  localparam logic [3:0] REG_DEST16  = 4'h7; // dest_index16
  localparam int        EXTRA_CYCLES = 1;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;

endpackage

// ===== seg_bases_if.sv
`timescale 1ns/10ps
// segment bases presented to the offset/selection stage
interface seg_bases_if;
  logic [31:0] base [6];
  logic [2:0]  sel;
  logic [31:0] chosen;

  modport owner (input base, input sel, output chosen);
  modport user  (output base, output sel, input chosen);
endinterface

// ===== seg_base_mux.sv
`timescale 1ns/10ps
// picks the selected segment base; bases are free to overlap
module seg_base_mux
(
  seg_bases_if.owner sb
);
  import addr_gen_pkg::*;

  // unused codes fall back to zero rather than aliasing a segment
  always_comb
  begin
    if (sb.sel < 3'h6)
    begin
      sb.chosen = sb.base[sb.sel]; // RL13
    end
    else
    begin
      sb.chosen = RESET_WORD;
    end
  end
endmodule // seg_base_mux

// ===== segmented_address_generation.sv
`timescale 1ns/10ps
// Overview of operation
// (RL1) multi-byte values occupy ascending bytes, LSB first
// (RL2) value address is its least significant byte
// (RL3) linear equals segment base plus offset
// (RL4) drive only low 24 linear bits
// (RL5) offset sums selected base, index, displacement
// (RL6) code fetch uses code segment, no override
// (RL7) data defaults data segment, stack to stack
// (RL8) push-type stores use stack, ignore override
// (RL9) pop-type reads use stack, no override
// (RL10) string destinations use string target segment
// (RL11) frame or stack base defaults stack segment
// (RL12) override replaces default for other data
// (RL13) segment bases may overlap freely
// (RL14) displacement is 8, 16 or 32 bits
// (RL15) 16-bit addressing base only base or frame
// (RL16) index excludes stack pointer, scaled 1/2/4/8
// (RL17) 16-bit addressing: no scale, source/dest index
// (RL18) eight modes, six memory modes
// (RL19) base plus index costs one extra clock
// (RL20) register or immediate operand sourcing
// (RL21) default 32-bit, prefixes switch per instruction
// (RL22) additions wrap modulo two to thirty-two
// (RL23) 16-bit offset sum zero-extended
module segmented_address_generation
(
  input  wire logic                CLK,
  input  wire logic                RSTN,
  // request from the decoder
  input  wire logic                REQ_VALID,
  output logic                     REQ_READY,
  input  wire addr_gen_pkg::ref_t  REF_KIND,
  input  wire addr_gen_pkg::mode_t MODE,
  input  wire logic                ADDR_LEN_OVR,
  input  wire logic                OPND_LEN_OVR,
  input  wire logic                SEG_OVR_VALID,
  input  wire addr_gen_pkg::seg_t  SEG_OVR,
  input  wire logic [3:0]          BASE_SEL,
  input  wire logic [3:0]          INDEX_SEL,
  input  wire logic [1:0]          SCALE,
  input  wire addr_gen_pkg::disp_t DISP_KIND,
  input  wire logic [31:0]         DISP,
  input  wire logic [31:0]         IMMEDIATE,
  input  wire addr_gen_pkg::size_t_t OPND_SIZE,
  input  wire logic [31:0]         INSTR_PTR,
  input  wire logic [255:0]        GP_REGS,
  input  wire logic [191:0]        SEG_BASES,
  input  wire logic [31:0]         STORE_DATA,
  // answer toward the bus unit
  output logic                     ADDR_VALID,
  output logic [23:0]              PHYS_ADDR,
  output logic [31:0]              LINEAR_ADDR,
  output logic [31:0]              OPERAND_OFFSET,
  output logic [2:0]               SEG_USED,
  output logic                     MEM_REF,
  output logic [31:0]              OPERAND,
  output logic [1:0]               BYTE_COUNT,
  output logic [31:0]              BYTE_LANES,
  output logic                     BAD_REG
);
  import addr_gen_pkg::*;
  // read one general register by index
  function automatic logic [31:0] gp(input logic [255:0] regs, input logic [3:0] idx);
    gp = regs[idx[2:0]*32 +: 32];
  endfunction
  // sign-extend a displacement of the given width
  function automatic logic [31:0] disp_ext(input disp_t k, input logic [31:0] d);
    case (k)
      DISP_8:  disp_ext = {{24{d[7]}}, d[7:0]};
      DISP_16: disp_ext = {{16{d[15]}}, d[15:0]};
      DISP_32: disp_ext = d;
      default: disp_ext = RESET_WORD;
    endcase
  endfunction
  seg_bases_if sb();
  state_t      state;
  state_t      next_state;
  logic [31:0] partial;
  logic [31:0] next_partial;
  logic [31:0] held_disp;
  logic [31:0] next_held_disp;
  logic [2:0]  held_seg;
  logic [2:0]  next_held_seg;
  logic        held_a16;
  logic        next_held_a16;
  logic        addr_valid;
  logic        next_addr_valid;
  logic [31:0] offset_q;
  logic [31:0] next_offset_q;
  logic [31:0] linear_q;
  logic [31:0] next_linear_q;
  logic [2:0]  seg_q;
  logic [2:0]  next_seg_q;
  logic        mem_q;
  logic        next_mem_q;
  logic [31:0] operand_q;
  logic [31:0] next_operand_q;
  logic [1:0]  count_q;
  logic [1:0]  next_count_q;
  logic [31:0] lanes_q;
  logic [31:0] next_lanes_q;
  logic        bad_q;
  logic        next_bad_q;
  logic        use_base;
  logic        use_index;
  logic        use_disp;
  logic        is_mem;
  logic [31:0] base_val;
  logic [31:0] index_val;
  logic [31:0] scaled;
  logic [31:0] dval;
  logic [2:0]  seg_pick;
  logic        bad_sel;
  logic [31:0] sum_now;
  // unpack segment bases for the selector
  always_comb
  begin
    for (int i = 0; i < 6; i++)
    begin
      sb.base[i] = SEG_BASES[i*32 +: 32];
    end
  end
  seg_base_mux u_seg_mux
  (
    .sb (sb)
  );

  // decode which components the mode contributes
  always_comb
  begin
    use_base  = 1'b0;
    use_index = 1'b0;
    use_disp  = 1'b0;
    is_mem    = 1'b1;
    case (MODE)
      MODE_REGISTER, MODE_IMMEDIATE: is_mem = 1'b0; // RL18
      MODE_DIRECT:         use_disp = 1'b1;
      MODE_REG_INDIRECT:   use_base = 1'b1;
      MODE_BASED:
      begin
        use_base = 1'b1;
        use_disp = 1'b1;
      end
      MODE_SCALED_INDEX:
      begin
        use_index = 1'b1;
        use_disp  = 1'b1;
      end
      MODE_BASED_SCALED:
      begin
        use_base  = 1'b1;
        use_index = 1'b1;
      end
      MODE_BASED_SCALED_D:
      begin
        use_base  = 1'b1;
        use_index = 1'b1;
        use_disp  = 1'b1;
      end
      default:             is_mem = 1'b0;
    endcase
  end

  // component values; 16-bit addressing narrows the register choice
  always_comb
  begin
    bad_sel   = 1'b0;
    base_val  = RESET_WORD;
    index_val = RESET_WORD;
    if (use_base)
    begin
      if (ADDR_LEN_OVR)
      begin
        base_val = gp(GP_REGS, BASE_SEL) & 32'h0000_FFFF; // RL15
        bad_sel  = (BASE_SEL != REG_BASE16) && (BASE_SEL != REG_FRAME);
      end
      else
      begin
        base_val = gp(GP_REGS, BASE_SEL);
        bad_sel  = BASE_SEL[3];
      end
    end
    if (use_index)
    begin
      if (ADDR_LEN_OVR)
      begin
        index_val = gp(GP_REGS, INDEX_SEL) & 32'h0000_FFFF; // RL17
        bad_sel   = bad_sel || ((INDEX_SEL != REG_SRC16) && (INDEX_SEL != REG_DEST16));
      end
      else
      begin
        index_val = gp(GP_REGS, INDEX_SEL);
        bad_sel   = bad_sel || (INDEX_SEL == REG_STACK) || INDEX_SEL[3]; // RL16
      end
    end
    // scaling only exists with 32-bit addressing
    scaled = ADDR_LEN_OVR ? index_val : (index_val << SCALE); // RL16 RL17
    dval   = use_disp ? disp_ext(DISP_KIND, DISP) : RESET_WORD; // RL14
    // 32-bit wrap: carries out of bit 31 are simply dropped
    sum_now = base_val + scaled + dval; // RL5 RL22
  end

  // segment choice: forced segments first, then override, then default
  always_comb
  begin
    case (REF_KIND)
      REF_CODE_FETCH:  seg_pick = SEG_CODE; // RL6
      REF_STACK_PUSH:  seg_pick = SEG_STACK; // RL8
      REF_STACK_POP:   seg_pick = SEG_STACK; // RL9
      REF_STRING_DEST: seg_pick = SEG_STRING_TARGET; // RL10
      default:
      begin
        if (SEG_OVR_VALID && (SEG_OVR <= SEG_AUX_TWO))
        begin
          seg_pick = SEG_OVR; // RL12
        end
        else if (use_base && ((BASE_SEL == REG_FRAME) || (!ADDR_LEN_OVR && (BASE_SEL == REG_STACK))))
        begin
          seg_pick = SEG_STACK; // RL11
        end
        else
        begin
          seg_pick = SEG_DATA; // RL7
        end
      end
    endcase
  end

  assign sb.sel    = (state == ST_EXTRA) ? held_seg : seg_pick;
  assign REQ_READY = (state != ST_EXTRA);

  // offset/linear pipeline; base plus index spends one extra cycle
  always_comb
  begin
    logic [31:0] off;
    logic        fetch;
    off             = RESET_WORD;
    fetch           = (REF_KIND == REF_CODE_FETCH);
    next_state      = state;
    next_partial    = partial;
    next_held_disp  = held_disp;
    next_held_seg   = held_seg;
    next_held_a16   = held_a16;
    next_addr_valid = 1'b0;
    next_offset_q   = offset_q;
    next_linear_q   = linear_q;
    next_seg_q      = seg_q;
    next_mem_q      = mem_q;
    next_operand_q  = operand_q;
    next_count_q    = count_q;
    next_lanes_q    = lanes_q;
    next_bad_q      = bad_q;
    case (state)
      ST_EXTRA:
      begin
        off = partial + held_disp; // RL22
        if (held_a16)
        begin
          off = {16'h0000, off[15:0]}; // RL23
        end
        next_offset_q   = off;
        next_linear_q   = sb.chosen + off; // RL3 RL22
        next_addr_valid = 1'b1;
        next_state      = ST_IDLE;
      end
      default:
      begin
        if (REQ_VALID)
        begin
          next_seg_q = seg_pick;
          next_bad_q = bad_sel;
          // operand width: 32 by default, 16 under the prefix
          if (OPND_SIZE == SIZE_8)
          begin
            next_count_q = 2'h0;
          end
          else if ((OPND_SIZE == SIZE_16) || OPND_LEN_OVR)
          begin
            next_count_q = 2'h1; // RL21
          end
          else
          begin
            next_count_q = 2'h3; // RL21
          end
          // store data split into bytes, least significant at lowest address
          next_lanes_q = STORE_DATA; // RL1 RL2
          if (!is_mem && !fetch)
          begin
            next_mem_q      = 1'b0;
            next_operand_q  = (MODE == MODE_IMMEDIATE) ? IMMEDIATE : gp(GP_REGS, BASE_SEL); // RL20
            next_addr_valid = 1'b1;
          end
          else if (use_base && use_index && !fetch)
          begin
            next_mem_q     = 1'b1;
            next_partial   = base_val + scaled; // RL19
            next_held_disp = dval;
            next_held_seg  = seg_pick;
            next_held_a16  = ADDR_LEN_OVR;
            next_state     = ST_EXTRA; // RL19
          end
          else
          begin
            off = fetch ? INSTR_PTR : sum_now; // RL6
            if (ADDR_LEN_OVR && !fetch)
            begin
              off = {16'h0000, off[15:0]}; // RL23 RL21
            end
            next_mem_q      = 1'b1;
            next_offset_q   = off;
            next_linear_q   = sb.chosen + off; // RL3
            next_addr_valid = 1'b1;
          end
        end
      end
    endcase
  end

  // registers only
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      state      <= ST_IDLE;
      partial    <= RESET_WORD;
      held_disp  <= RESET_WORD;
      held_seg   <= 3'h0;
      held_a16   <= 1'b0;
      addr_valid <= 1'b0;
      offset_q   <= RESET_WORD;
      linear_q   <= RESET_WORD;
      seg_q      <= 3'h0;
      mem_q      <= 1'b0;
      operand_q  <= RESET_WORD;
      count_q    <= 2'h0;
      lanes_q    <= RESET_WORD;
      bad_q      <= 1'b0;
    end
    else
    begin
      state      <= next_state;
      partial    <= next_partial;
      held_disp  <= next_held_disp;
      held_seg   <= next_held_seg;
      held_a16   <= next_held_a16;
      addr_valid <= next_addr_valid;
      offset_q   <= next_offset_q;
      linear_q   <= next_linear_q;
      seg_q      <= next_seg_q;
      mem_q      <= next_mem_q;
      operand_q  <= next_operand_q;
      count_q    <= next_count_q;
      lanes_q    <= next_lanes_q;
      bad_q      <= next_bad_q;
    end
  end

  // outputs, all from flip-flops
  assign ADDR_VALID     = addr_valid;
  assign OPERAND_OFFSET = offset_q;
  assign LINEAR_ADDR    = linear_q;
  assign PHYS_ADDR      = linear_q[PHYS_WIDTH-1:0]; // RL4
  assign SEG_USED       = seg_q;
  assign MEM_REF        = mem_q;
  assign OPERAND        = operand_q;
  assign BYTE_COUNT     = count_q;
  assign BYTE_LANES     = lanes_q; // RL1
  assign BAD_REG        = bad_q;
endmodule // segmented_address_generation

// ===== bus_sink.sv
`timescale 1ns/10ps
// bus unit stand-in: takes every address result, never stalls (the block has no back-pressure input)
module bus_sink
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        valid,
  input  wire logic [23:0] phys,
  output int               count,
  output logic [23:0]      last_phys
);
  // count results so the bench can prove none were lost or duplicated
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      count     <= 0;
      last_phys <= 24'h000000;
    end
    else if (valid)
    begin
      count     <= count + 1;
      last_phys <= phys;
    end
  end
endmodule // bus_sink

// ===== sag_chk.sv
`timescale 1ns/10ps
module sag_chk
  import addr_gen_pkg::*;
(
  input  wire logic                CLK,
  input  wire logic                RSTN,
  input  wire logic                REQ_VALID,
  input  wire logic                REQ_READY,
  input  wire addr_gen_pkg::ref_t  REF_KIND,
  input  wire addr_gen_pkg::mode_t MODE,
  input  wire logic                ADDR_LEN_OVR,
  input  wire logic                SEG_OVR_VALID,
  input  wire addr_gen_pkg::seg_t  SEG_OVR,
  input  wire logic [3:0]          BASE_SEL,
  input  wire logic [31:0]         INSTR_PTR,
  input  wire logic [191:0]        SEG_BASES,
  input  wire logic [31:0]         STORE_DATA,
  input  wire logic                ADDR_VALID,
  input  wire logic [23:0]         PHYS_ADDR,
  input  wire logic [31:0]         LINEAR_ADDR,
  input  wire logic [31:0]         OPERAND_OFFSET,
  input  wire logic [2:0]          SEG_USED,
  input  wire logic                MEM_REF,
  input  wire logic [1:0]          BYTE_COUNT,
  input  wire logic [31:0]         BYTE_LANES
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  // request taken, and whether it needs the extra base+index clock
  wire tk = REQ_VALID && REQ_READY;
  wire bi = (MODE == MODE_BASED_SCALED || MODE == MODE_BASED_SCALED_D) && REF_KIND != REF_CODE_FETCH;
  wire dat = tk && REF_KIND == REF_DATA && MODE >= MODE_DIRECT && !bi;

  a_phys_trunc: assert property (ADDR_VALID && MEM_REF |-> PHYS_ADDR == LINEAR_ADDR[23:0])
    else $error("physical address is not the low linear bits");
  a_linear_sum: assert property (ADDR_VALID && MEM_REF && SEG_USED < 3'h6
    |-> LINEAR_ADDR == SEG_BASES[{SEG_USED, 5'h00} +: 32] + OPERAND_OFFSET)
    else $error("linear address is not base plus offset");
  a_code_seg: assert property (tk && REF_KIND == REF_CODE_FETCH |=> ADDR_VALID && SEG_USED == SEG_CODE
    && OPERAND_OFFSET == $past(INSTR_PTR)) else $error("code fetch segment or offset wrong");
  a_stack_ops: assert property (tk && (REF_KIND == REF_STACK_PUSH || REF_KIND == REF_STACK_POP)
    |-> ##[1:2] (ADDR_VALID && SEG_USED == SEG_STACK)) else $error("stack op not on stack segment");
  a_string_seg: assert property (tk && REF_KIND == REF_STRING_DEST
    |-> ##[1:2] (ADDR_VALID && SEG_USED == SEG_STRING_TARGET)) else $error("string target segment wrong");
  a_base_default: assert property (dat && !SEG_OVR_VALID && !ADDR_LEN_OVR && MODE != MODE_DIRECT
    && MODE != MODE_SCALED_INDEX
    |=> SEG_USED == (($past(BASE_SEL) == REG_STACK || $past(BASE_SEL) == REG_FRAME) ? SEG_STACK : SEG_DATA))
    else $error("default data segment wrong");
  a_ovr_select: assert property (dat && SEG_OVR_VALID && SEG_OVR < 3'h6 |=> SEG_USED == $past(SEG_OVR))
    else $error("override not applied");
  a_extra_clk: assert property (tk && bi |=> !REQ_READY && !ADDR_VALID ##1 ADDR_VALID)
    else $error("base plus index timing wrong");
  a_single_clk: assert property (tk && !bi |=> ADDR_VALID)
    else $error("result not in the next cycle");
  a_lane_order: assert property (tk |=> BYTE_LANES == $past(STORE_DATA))
    else $error("byte lane order wrong");

  c_extra: cover property (tk && bi);
  c_ovr: cover property (tk && SEG_OVR_VALID && REF_KIND == REF_DATA);
  c_code: cover property (tk && REF_KIND == REF_CODE_FETCH);
endmodule // sag_chk

bind segmented_address_generation sag_chk u_chk (.CLK(CLK), .RSTN(RSTN), .REQ_VALID(REQ_VALID),
  .REQ_READY(REQ_READY), .REF_KIND(REF_KIND), .MODE(MODE), .ADDR_LEN_OVR(ADDR_LEN_OVR),
  .SEG_OVR_VALID(SEG_OVR_VALID), .SEG_OVR(SEG_OVR), .BASE_SEL(BASE_SEL), .INSTR_PTR(INSTR_PTR),
  .SEG_BASES(SEG_BASES), .STORE_DATA(STORE_DATA), .ADDR_VALID(ADDR_VALID), .PHYS_ADDR(PHYS_ADDR),
  .LINEAR_ADDR(LINEAR_ADDR), .OPERAND_OFFSET(OPERAND_OFFSET), .SEG_USED(SEG_USED), .MEM_REF(MEM_REF),
  .BYTE_COUNT(BYTE_COUNT), .BYTE_LANES(BYTE_LANES));

// ===== tb_segmented_address_generation.sv
`timescale 1ns/10ps
module tb_segmented_address_generation;
  import addr_gen_pkg::*;
  logic clk = 0, rstn = 0, req_valid = 0, alo = 0, olo = 0, ovr_v = 0;
  ref_t rk = REF_DATA;
  mode_t md = MODE_DIRECT;
  seg_t ovr = SEG_DATA;
  disp_t dk = DISP_NONE;
  size_t_t osz = SIZE_32;
  logic [3:0] bsel = 0, isel = 0;
  logic [1:0] sc = 0;
  logic [31:0] disp = 0, imm = 32'h5A5A_0F0F, ip = 0, sd = 0, lin, off, opnd, lanes;
  logic [255:0] gp;
  logic [191:0] sb;
  logic req_ready, addr_valid, mem_ref, bad_reg;
  logic [23:0] phys, lp;
  logic [2:0] segu, s;
  logic [1:0] bc;
  int fail_count = 0, n_compared = 0, nreq = 0, cnt;

  segmented_address_generation dut (.CLK(clk), .RSTN(rstn), .REQ_VALID(req_valid), .REQ_READY(req_ready),
    .REF_KIND(rk), .MODE(md), .ADDR_LEN_OVR(alo), .OPND_LEN_OVR(olo), .SEG_OVR_VALID(ovr_v), .SEG_OVR(ovr),
    .BASE_SEL(bsel), .INDEX_SEL(isel), .SCALE(sc), .DISP_KIND(dk), .DISP(disp), .IMMEDIATE(imm),
    .OPND_SIZE(osz), .INSTR_PTR(ip), .GP_REGS(gp), .SEG_BASES(sb), .STORE_DATA(sd), .ADDR_VALID(addr_valid),
    .PHYS_ADDR(phys), .LINEAR_ADDR(lin), .OPERAND_OFFSET(off), .SEG_USED(segu), .MEM_REF(mem_ref),
    .OPERAND(opnd), .BYTE_COUNT(bc), .BYTE_LANES(lanes), .BAD_REG(bad_reg));
  bus_sink snk (.clk(clk), .rstn(rstn), .valid(addr_valid), .phys(phys), .count(cnt), .last_phys(lp));

  always #5 clk = ~clk;

  task end_of_test();
    if (fail_count == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // reference offset; under 16-bit addressing the sum wraps at 16 bits and scale is dropped
  function automatic logic [31:0] ea();
    logic [31:0] b, i, d;
    d = dk == DISP_8 ? {{24{disp[7]}}, disp[7:0]} : dk == DISP_16 ? {{16{disp[15]}}, disp[15:0]} :
        dk == DISP_32 ? disp : 32'h0;
    b = gp[32*bsel +: 32];
    i = gp[32*isel +: 32];
    if (alo)
    begin
      b = {16'h0, b[15:0]};
      i = {16'h0, i[15:0]};
    end
    else
      i = i << sc;
    case (md)
      MODE_DIRECT: ea = d;
      MODE_REG_INDIRECT: ea = b;
      MODE_BASED: ea = b + d;
      MODE_SCALED_INDEX: ea = i + d;
      MODE_BASED_SCALED: ea = b + i;
      default: ea = b + i + d;
    endcase
    if (alo)
      ea = {16'h0, ea[15:0]};
  endfunction

  // one request, bounded wait for the result, then one idle cycle so inputs stay put while it is sampled
  task go(input int lat);
    int n;
    req_valid = 1;
    nreq++;
    @(negedge clk);
    req_valid = 0;
    if (lat == 2)
      chk(req_ready, 0);
    n = 1;
    while (addr_valid !== 1'b1 && n < 5)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= 5)
    begin
      chk(0, 1);
      end_of_test();
    end
    chk(n, lat);
    @(posedge clk);
    @(negedge clk);
  endtask

  task exp_out(input logic [2:0] sg, input logic [31:0] o);
    chk(segu, sg);
    chk(off, o);
    chk(lin, sb[{sg, 5'h00} +: 32] + o);
    chk(phys, lin[23:0]);
  endtask

  task t_code();
    rk = REF_CODE_FETCH;
    md = MODE_BASED_SCALED_D;
    ovr_v = 1;
    ip = 32'h0000_2000;
    sb[32 +: 32] = 32'hFFFF_F000;
    go(1);
    exp_out(SEG_CODE, ip);
    chk(lin, 32'h0000_1000);
  endtask

  task t_fixed();
    ref_t k[3] = '{REF_STACK_PUSH, REF_STACK_POP, REF_STRING_DEST};
    seg_t e[3] = '{SEG_STACK, SEG_STACK, SEG_STRING_TARGET};
    ovr = SEG_AUX_TWO;
    md = MODE_BASED;
    bsel = 7;
    dk = DISP_8;
    disp = 32'h0000_00F0;
    for (int j = 0; j < 3; j++)
    begin
      rk = k[j];
      go(1);
      exp_out(e[j], ea());
    end
  endtask

  task t_defaults();
    rk = REF_DATA;
    ovr_v = 0;
    md = MODE_REG_INDIRECT;
    for (int b = 0; b < 8; b++)
    begin
      bsel = 4'(b);
      go(1);
      exp_out((b == 4 || b == 5) ? SEG_STACK : SEG_DATA, gp[32*b +: 32]);
    end
  endtask

  task t_override();
    md = MODE_BASED;
    bsel = 5;
    dk = DISP_32;
    disp = 32'hFFFF_FFFC;
    ovr_v = 1;
    for (int o = 0; o < 8; o++)
    begin
      ovr = seg_t'(o);
      s = o < 6 ? 3'(o) : SEG_STACK;
      go(1);
      exp_out(s, ea());
    end
    ovr_v = 0;
  endtask

  task t_modes();
    bsel = 1;
    isel = 2;
    disp = 32'h0000_8001;
    for (int m = 2; m < 8; m++)
      for (int k = 0; k < 4; k++)
      begin
        md = mode_t'(m);
        sc = 2'(k);
        dk = disp_t'(k);
        go(m >= 6 ? 2 : 1);
        exp_out(SEG_DATA, ea());
      end
    md = MODE_SCALED_INDEX;
    isel = 4;
    go(1);
    chk(bad_reg, 1);
  endtask

  task t_addr16();
    alo = 1;
    md = MODE_BASED_SCALED_D;
    sc = 3;
    dk = DISP_8;
    disp = 32'h0000_0010;
    for (int j = 0; j < 2; j++)
    begin
      bsel = j ? 5 : 3;
      isel = j ? 7 : 6;
      go(2);
      exp_out(j ? SEG_STACK : SEG_DATA, ea());
      chk(bad_reg, 0);
    end
    bsel = 0;
    go(2);
    chk(bad_reg, 1);
    alo = 0;
    md = MODE_REG_INDIRECT;
    bsel = 3;
    go(1);
    chk(off, gp[96 +: 32]);
  endtask

  task t_operand();
    md = MODE_REGISTER;
    bsel = 2;
    go(1);
    chk(opnd, gp[64 +: 32]);
    chk(mem_ref, 0);
    md = MODE_IMMEDIATE;
    go(1);
    chk(opnd, imm);
  endtask

  task t_lanes();
    md = MODE_REG_INDIRECT;
    bsel = 0;
    sd = 32'h1122_3344;
    for (int j = 3; j >= 0; j--)
    begin
      // pass 3 is a 32-bit operand narrowed by the operand length prefix
      osz = size_t_t'(j == 3 ? 2 : j);
      olo = (j == 3);
      go(1);
      chk(bc, j == 3 ? 1 : j == 2 ? 3 : j);
      chk(lanes[7:0], 8'h44);
      if (j == 2)
        chk(lanes, sd);
    end
  endtask

  initial
  begin
    for (int i = 0; i < 8; i++)
      gp[32*i +: 32] = 32'h0101_0111 * (i + 1);
    gp[96 +: 32] = 32'hABCD_F000;
    gp[192 +: 32] = 32'h1234_2000;
    for (int i = 0; i < 6; i++)
      sb[32*i +: 32] = 32'h0110_0000 * (i + 1);
    repeat (6) @(negedge clk);
    rstn = 1;
    chk(req_ready, 1);
    chk(addr_valid, 0);
    t_code();
    t_fixed();
    t_defaults();
    t_override();
    t_modes();
    t_addr16();
    t_operand();
    t_lanes();
    // identical zero bases: physical address is the bare offset
    sb = '0;
    md = MODE_REG_INDIRECT;
    bsel = 3;
    go(1);
    chk(phys, 24'hCDF000);
    chk(lp, 24'hCDF000);
    chk(cnt, nreq);
    end_of_test();
  end
endmodule // tb_segmented_address_generation
